// ===== src/srg_group.sv
// Status register group: condition, edge filters, sticky events, mask, summary.
//
// The register offsets and the APB slave port are this design's own decisions.
`timescale 1ns/1ns
`include "srg_params.svh"
module srg_group (
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire srg_pkg::srg_word_t cond_in,
    input wire srg_pkg::srg_word_t direct_event,
    input wire logic q_push,
    input wire srg_pkg::srg_word_t q_push_data,
    output logic q_full,
    output logic summary,
    output logic queue_summary
);
    import srg_pkg::*;

    // Pin inputs are three-stage synchronised; changes count when stages 2 and 3 agree.
    srg_word_t cond_s1;
    srg_word_t cond_s2;
    srg_word_t cond_s3;
    srg_word_t live_condition;
    srg_word_t cond_prev;
    srg_word_t rising_edge_filter;
    srg_word_t falling_edge_filter;
    srg_word_t latched_events;
    srg_word_t event_mask;
    srg_word_t q_head;
    logic [`SRG_Q_AW:0] q_count;
    logic q_not_empty;

    // Bits agreeing between stages 2 and 3 update the stable condition.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            cond_s1 <= '0;
            cond_s2 <= '0;
            cond_s3 <= '0;
            live_condition <= '0;
        end else if (ce) begin
            cond_s1 <= cond_in;
            cond_s2 <= cond_s1;
            cond_s3 <= cond_s2;
            live_condition <= (~(cond_s2 ^ cond_s3) & cond_s3 & `SRG_USED_MASK) |
                ((cond_s2 ^ cond_s3) & live_condition);
        end
    end

    // APB decode: every transfer completes in its first access cycle.
    wire access = psel && penable;
    wire wr = access && pwrite;
    wire rd = access && !pwrite;
    wire hit_cond = (paddr == `SRG_OFF_COND);
    wire hit_ptr = (paddr == `SRG_OFF_PTR);
    wire hit_ntr = (paddr == `SRG_OFF_NTR);
    wire hit_event = (paddr == `SRG_OFF_EVENT);
    wire hit_mask = (paddr == `SRG_OFF_MASK);
    wire hit_ctrl = (paddr == `SRG_OFF_CTRL);
    wire hit_qdata = (paddr == `SRG_OFF_QDATA);
    wire hit_qstat = (paddr == `SRG_OFF_QSTAT);
    wire mapped = hit_cond || hit_ptr || hit_ntr || hit_event || hit_mask ||
        hit_ctrl || hit_qdata || hit_qstat;
    // Writes to read-only registers are reported as errors, as are unmapped ones.
    wire bad = !mapped || (pwrite && (hit_cond || hit_event || hit_qstat || hit_qdata));
    assign pready = 1'b1;
    assign pslverr = access && bad;

    wire clear_status = wr && hit_ctrl && pwdata[`SRG_CTRL_CLS];
    wire reset_cmd = wr && hit_ctrl && pwdata[`SRG_CTRL_RST];
    wire event_query = rd && hit_event;

    // Edge detect on the stable condition, qualified per bit by the filters.
    wire [15:0] rise = live_condition & ~cond_prev & rising_edge_filter;
    wire [15:0] fall = ~live_condition & cond_prev & falling_edge_filter;
    wire [15:0] new_events = (rise | fall | direct_event) & `SRG_USED_MASK;
    wire clear_events = clear_status || event_query;
    // A query clears only the bits that its setup cycle returned in prdata.
    // A bit that lands between setup and access was never reported, so it survives.
    wire [15:0] query_bits = event_query ? prdata[15:0] : 16'h0000;
    wire [15:0] clear_bits = clear_status ? `SRG_USED_MASK : query_bits;
    // A set bit just stays set; new events beat a clear in the same cycle.
    wire [15:0] next_events = (latched_events & ~clear_bits) |
        new_events;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            cond_prev <= '0;
            latched_events <= '0;
        end else if (ce) begin
            cond_prev <= live_condition;
            latched_events <= next_events;
        end
    end

    // Filters and mask: only direct writes and the reset command touch them.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            rising_edge_filter <= `SRG_PTR_RESET;
            falling_edge_filter <= `SRG_NTR_RESET;
            event_mask <= '0;
        end else if (ce) begin
            if (reset_cmd) begin
                rising_edge_filter <= `SRG_PTR_RESET;
                falling_edge_filter <= `SRG_NTR_RESET;
            end else begin
                if (wr && hit_ptr) rising_edge_filter <= pwdata[15:0];
                if (wr && hit_ntr) falling_edge_filter <= pwdata[15:0];
            end
            if (wr && hit_mask) event_mask <= pwdata[15:0] & `SRG_USED_MASK;
        end
    end

    // The mask being written counts at once, so the summary never lags a mask write.
    wire [15:0] mask_wdata = pwdata[15:0] & `SRG_USED_MASK;
    wire [15:0] next_mask = (wr && hit_mask) ? mask_wdata : event_mask;

    // Summary feeds one bit of a higher register; it is registered for a clean output.
    // It is built from next values so it always equals the OR of the current registers.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            summary <= 1'b0;
        end else if (ce) begin
            summary <= |(next_events & next_mask);
        end
    end

    // Read mux; the event query clears one edge after the setup edge that returns the value.
    wire [31:0] rd_mux =
        hit_cond ? {16'h0000, live_condition} :
        hit_ptr ? {16'h0000, rising_edge_filter} :
        hit_ntr ? {16'h0000, falling_edge_filter} :
        hit_event ? {16'h0000, latched_events} :
        hit_mask ? {16'h0000, event_mask} :
        hit_qdata ? {16'h0000, q_head} :
        hit_qstat ? {27'h0, q_count, q_not_empty} : 32'h00000000;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            prdata <= '0;
        end else if (ce && psel && !penable && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    // Queue read pops on access; clear-status flushes it.
    srg_queue u_queue (
        .clock(clock),
        .rstn(rstn),
        .ce(ce),
        .push(q_push),
        .push_data(q_push_data),
        .pop(rd && hit_qdata),
        .flush(clear_status),
        .head(q_head),
        .not_empty(q_not_empty),
        .full(q_full),
        .count(q_count)
    );
    assign queue_summary = q_not_empty;

    // Checks. Each one watches what the group drives, some of them triggered by what the bus master drives.
    // Bit positions differ between checks so that one stimulus does not mask another.

    // A filtered rising edge that meets no clear must be latched one edge later.
    sequence rise_seen_s;
        ce && rise[0] && !clear_events;
    endsequence
    event_rise_a: assert property (@(posedge clock) disable iff (!rstn)
        rise_seen_s |=> latched_events[0])
        else $error("Rising edge lost.");

    // With both filters off and no direct source, bit 1 never latches.
    fall_block_a: assert property (@(posedge clock) disable iff (!rstn)
        ce && !falling_edge_filter[1] && !rising_edge_filter[1] && !direct_event[1] &&
        (clear_events || !latched_events[1]) |=> !latched_events[1])
        else $error("Unfiltered edge latched.");

    // A set bit stays set while nothing clears it.
    sticky_hold_a: assert property (@(posedge clock) disable iff (!rstn)
        ce && latched_events[2] && !clear_events |=> latched_events[2])
        else $error("Event bit dropped.");

    // A new event in the clearing cycle wins over the clear.
    clear_race_a: assert property (@(posedge clock) disable iff (!rstn)
        ce && clear_events && new_events[3] |=> latched_events[3])
        else $error("Event lost to clear.");

    // The summary always equals the OR of enabled events held in the registers.
    summary_or_a: assert property (@(posedge clock) disable iff (!rstn)
        ce |=> summary == |(latched_events & event_mask))
        else $error("Summary wrong.");

    // Clear-status leaves filters and mask alone.
    filter_keep_a: assert property (@(posedge clock) disable iff (!rstn)
        ce && clear_status && !reset_cmd |=> $stable(rising_edge_filter) &&
        $stable(falling_edge_filter) && $stable(event_mask))
        else $error("Clear-status changed filters.");

    // The reset command restores the filter defaults.
    reset_cmd_a: assert property (@(posedge clock) disable iff (!rstn)
        ce && reset_cmd |=> rising_edge_filter == `SRG_PTR_RESET &&
        falling_edge_filter == `SRG_NTR_RESET)
        else $error("Reset command failed.");

    // A filtered falling edge always ends up latched.
    fall_seen_a: assert property (@(posedge clock) disable iff (!rstn)
        ce && fall[4] |=> latched_events[4])
        else $error("Falling edge lost.");

    // Once stages 2 and 3 agree the stable condition follows them.
    cond_track_a: assert property (@(posedge clock) disable iff (!rstn)
        ce && cond_s2 == cond_s3 |=> live_condition == $past(cond_s3))
        else $error("Condition not tracking.");

    // Power-on reset sets the filter defaults whatever the clock enable does.
    reset_value_a: assert property (@(posedge clock)
        !rstn |=> rising_edge_filter == `SRG_PTR_RESET &&
        falling_edge_filter == `SRG_NTR_RESET)
        else $error("Filter reset value wrong.");

    // A write to the rising filter lands whole.
    ptr_write_a: assert property (@(posedge clock) disable iff (!rstn)
        ce && wr && hit_ptr && !reset_cmd |=> rising_edge_filter == $past(pwdata[15:0]))
        else $error("Rising filter write lost.");

    // A write to the falling filter lands whole and apart from the rising one.
    ntr_write_a: assert property (@(posedge clock) disable iff (!rstn)
        ce && wr && hit_ntr && !reset_cmd |=> falling_edge_filter == $past(pwdata[15:0]))
        else $error("Falling filter write lost.");

    // Filters move only on their own write or the reset command; queries leave them.
    filter_hold_a: assert property (@(posedge clock) disable iff (!rstn)
        ce && !reset_cmd && !(wr && (hit_ptr || hit_ntr)) |=>
        $stable(rising_edge_filter) && $stable(falling_edge_filter))
        else $error("Filter changed without a write.");

    // The mask keeps only used positions of a write.
    mask_write_a: assert property (@(posedge clock) disable iff (!rstn)
        ce && wr && hit_mask |=> event_mask == ($past(pwdata[15:0]) & `SRG_USED_MASK))
        else $error("Mask write wrong.");

    // The mask moves only on its own write.
    mask_keep_a: assert property (@(posedge clock) disable iff (!rstn)
        ce && !(wr && hit_mask) |=> $stable(event_mask))
        else $error("Mask changed without a write.");

    // Clear-status with no new event empties the event register.
    status_clear_a: assert property (@(posedge clock) disable iff (!rstn)
        ce && clear_status && new_events == 16'h0000 |=> latched_events == 16'h0000)
        else $error("Clear-status left events.");

    // A query clears every bit it returned unless that bit is set again.
    query_clear_a: assert property (@(posedge clock) disable iff (!rstn)
        ce && event_query && new_events == 16'h0000 |=>
        (latched_events & $past(prdata[15:0])) == 16'h0000)
        else $error("Query left reported events.");

    // With both filters on, either edge of bit 6 latches.
    sequence edge_pair_s;
        ce && rising_edge_filter[6] && falling_edge_filter[6] &&
        (live_condition[6] != cond_prev[6]);
    endsequence
    both_edge_a: assert property (@(posedge clock) disable iff (!rstn)
        edge_pair_s |=> latched_events[6])
        else $error("Edge with both filters lost.");

    // A rising edge of bit 7 with its rising filter off stays out.
    sequence rise_blocked_s;
        ce && !rising_edge_filter[7] && live_condition[7] && !cond_prev[7] &&
        !direct_event[7] && !latched_events[7];
    endsequence
    rise_block_a: assert property (@(posedge clock) disable iff (!rstn)
        rise_blocked_s |=> !latched_events[7])
        else $error("Blocked rising edge latched.");

    // A direct occurrence sets its bit with no filter in the way.
    direct_set_a: assert property (@(posedge clock) disable iff (!rstn)
        ce && direct_event[8] |=> latched_events[8])
        else $error("Direct occurrence lost.");

    // Unused condition positions never show a one.
    unused_zero_a: assert property (@(posedge clock) disable iff (!rstn)
        (live_condition & ~`SRG_USED_MASK) == 16'h0000)
        else $error("Unused condition bit set.");

    // The queue summary pin tracks occupancy.
    queue_flag_a: assert property (@(posedge clock) disable iff (!rstn)
        queue_summary == (q_count != '0))
        else $error("Queue summary wrong.");

    // Unmapped accesses always raise the error response.
    refuse_err_a: assert property (@(posedge clock) disable iff (!rstn)
        psel && penable && !mapped |-> pslverr)
        else $error("Unmapped access not refused.");

    // A low clock enable freezes events, mask and summary.
    freeze_hold_a: assert property (@(posedge clock) disable iff (!rstn)
        !ce |=> $stable(latched_events) && $stable(event_mask) && $stable(summary))
        else $error("State moved while frozen.");
endmodule

// ===== shared/srg_params.svh
// Constants of the status register group: offsets, widths, reset values.
// Contract
// - Condition register mirrors live state, read-only.
// - Condition is 16 bits; unassigned bits zero.
// - Rising edge latches only if rising filter set.
// - Falling edge latches only if falling filter set.
// - Both filters set: either edge latches.
// - Two separate 16-bit read-write filter registers.
// - Clear-status and queries keep filter values.
// - Reset: rising filters all one, falling zero.
// - Event bits sticky until read or clear-status.
// - Set event bit ignores further transitions.
// - Direct occurrences set event bits without filters.
// - Summary is OR of events AND mask.
// - Mask is read-write; unused positions read zero.
// - Clear-status and queries keep mask value.
// - Summary output feeds a higher register bit.
// - Queue summary high while queue not empty.
// - Queue empties on reads; clear-status flushes it.
`ifndef SRG_PARAMS_SVH
`define SRG_PARAMS_SVH
`define SRG_W 16
`define SRG_USED_MASK 16'hFFFF
`define SRG_PTR_RESET 16'hFFFF
`define SRG_NTR_RESET 16'h0000
`define SRG_OFF_COND 12'h000
`define SRG_OFF_PTR 12'h004
`define SRG_OFF_NTR 12'h008
`define SRG_OFF_EVENT 12'h00C
`define SRG_OFF_MASK 12'h010
`define SRG_OFF_CTRL 12'h014
`define SRG_OFF_QDATA 12'h018
`define SRG_OFF_QSTAT 12'h01C
`define SRG_CTRL_CLS 0
`define SRG_CTRL_RST 1
`define SRG_Q_DEPTH 8
`define SRG_Q_AW 3
`define SRG_Q_DW 16
`endif

// ===== shared/srg_pkg.sv
// Types shared by the status register group files.
package srg_pkg;
    typedef logic [15:0] srg_word_t;
    typedef enum logic [1:0] {SRG_IDLE, SRG_ACCESS} srg_apb_e;
endpackage

// ===== src/srg_queue.sv
// Status queue with a non-empty summary bit and a flush input.
`timescale 1ns/1ns
`include "srg_params.svh"
module srg_queue (
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    input wire logic push,
    input wire srg_pkg::srg_word_t push_data,
    input wire logic pop,
    input wire logic flush,
    output srg_pkg::srg_word_t head,
    output logic not_empty,
    output logic full,
    output logic [`SRG_Q_AW:0] count
);
    import srg_pkg::*;
    srg_word_t mem [0:`SRG_Q_DEPTH-1];
    logic [`SRG_Q_AW-1:0] wr_ptr;
    logic [`SRG_Q_AW-1:0] rd_ptr;
    wire do_pop = pop && not_empty;
    wire do_push = push && !full;

    // Summary bit tracks occupancy directly.
    assign not_empty = (count != '0);
    assign full = (count == (`SRG_Q_AW+1)'(`SRG_Q_DEPTH));
    assign head = mem[rd_ptr];

    // Storage write; no reset needed for data words.
    always_ff @(posedge clock) begin
        if (ce && do_push && !flush) begin
            mem[wr_ptr] <= push_data;
        end
    end

    // Pointers; flush drops all entries at once.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else if (ce) begin
            if (flush) begin
                wr_ptr <= '0;
                rd_ptr <= '0;
                count <= '0;
            end else begin
                if (do_push) wr_ptr <= wr_ptr + 1'b1;
                if (do_pop) rd_ptr <= rd_ptr + 1'b1;
                if (do_push && !do_pop) count <= count + 1'b1;
                else if (do_pop && !do_push) count <= count - 1'b1;
            end
        end
    end

    queue_summary_a: assert property (@(posedge clock) disable iff (!rstn)
        ce && flush |=> !not_empty) else $error("Queue not empty after flush.");
endmodule

// ===== sim/srg_host.sv
// APB master model standing for the program that reads the status group.
`timescale 1ns/1ns
module srg_host (
    input wire logic clock,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // The bus starts idle so nothing is requested during reset.
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    // The request stays put until pready is seen high; no wait count is assumed.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) begin
            @(posedge clock);
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// ===== sim/status_register_group_tb.sv
// Self-checking bench for the status register group.
`timescale 1ns/1ns
`include "srg_params.svh"
module status_register_group_tb;
    import srg_pkg::*;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, q_push, q_full, summary, queue_summary;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    srg_word_t cond_in = 16'h0000;
    srg_word_t direct_event = 16'h0000;
    srg_word_t q_push_data = 16'h0000;
    int fails = 0;
    int checks = 0;
    logic ce = 1'b1;
    initial q_push = 1'b0;
    // Clock enable is driven so that one scenario can freeze the group.
    srg_group srg_group_i (.clock(clock), .rstn(rstn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cond_in(cond_in),
        .direct_event(direct_event), .q_push(q_push), .q_push_data(q_push_data),
        .q_full(q_full), .summary(summary), .queue_summary(queue_summary));
    srg_host srg_host_i (.clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    initial begin
        forever #2 clock = ~clock;
    end
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        checks++;
        if (g !== x) begin
            fails++;
            $display("unexpected %s expected %h seen %h", n, x, g);
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        logic [31:0] q;
        logic e;
        srg_host_i.xfer(1'b0, a, 32'h0, q, e);
        chk($sformatf("reg %h", a), x, q);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        srg_host_i.xfer(1'b1, a, d, q, e);
    endtask
    // Condition changes need several edges to reach the event bits.
    task automatic set_cond(input srg_word_t v);
        @(posedge clock);
        cond_in <= v;
        repeat (8) @(posedge clock);
    endtask
    task automatic t_reset();
        rd(`SRG_OFF_PTR, 32'h0000FFFF);
        rd(`SRG_OFF_NTR, 32'h00000000);
        rd(`SRG_OFF_EVENT, 32'h00000000);
        chk("queue_summary", 32'h0, {31'h0, queue_summary});
    endtask
    // Filters first, then mask, as a program sets up a group.
    task automatic t_edges();
        wr(`SRG_OFF_PTR, 32'h00000005);
        wr(`SRG_OFF_NTR, 32'h00000006);
        set_cond(16'h000F);
        rd(`SRG_OFF_COND, 32'h0000000F);
        rd(`SRG_OFF_EVENT, 32'h00000005);
        rd(`SRG_OFF_EVENT, 32'h00000000);
        set_cond(16'h0000);
        rd(`SRG_OFF_EVENT, 32'h00000006);
        set_cond(16'h0001);
        set_cond(16'h0000);
        set_cond(16'h0001);
        rd(`SRG_OFF_EVENT, 32'h00000001);
        rd(`SRG_OFF_PTR, 32'h00000005);
        rd(`SRG_OFF_NTR, 32'h00000006);
    endtask
    // Direct occurrences feed the summary only where the mask allows.
    task automatic t_summary();
        wr(`SRG_OFF_MASK, 32'hFFFF0010);
        rd(`SRG_OFF_MASK, 32'h00000010);
        @(posedge clock);
        direct_event <= 16'h0020;
        @(posedge clock);
        direct_event <= 16'h0000;
        repeat (3) @(posedge clock);
        chk("summary", 32'h0, {31'h0, summary});
        direct_event <= 16'h0010;
        @(posedge clock);
        direct_event <= 16'h0000;
        repeat (3) @(posedge clock);
        chk("summary", 32'h1, {31'h0, summary});
        wr(`SRG_OFF_CTRL, 32'h00000001);
        repeat (2) @(posedge clock);
        chk("summary", 32'h0, {31'h0, summary});
        rd(`SRG_OFF_MASK, 32'h00000010);
    endtask
    task automatic t_queue();
        @(posedge clock);
        q_push <= 1'b1;
        q_push_data <= 16'hA5C3;
        @(posedge clock);
        q_push_data <= 16'h1234;
        @(posedge clock);
        q_push <= 1'b0;
        @(posedge clock);
        chk("queue_summary", 32'h1, {31'h0, queue_summary});
        chk("q_full", 32'h0, {31'h0, q_full});
        rd(`SRG_OFF_QDATA, 32'h0000A5C3);
        rd(`SRG_OFF_QSTAT, 32'h00000003);
        wr(`SRG_OFF_CTRL, 32'h00000001);
        @(posedge clock);
        chk("queue_summary", 32'h0, {31'h0, queue_summary});
        q_push <= 1'b1;
        repeat (`SRG_Q_DEPTH) @(posedge clock);
        q_push <= 1'b0;
        @(posedge clock);
        chk("q_full", 32'h1, {31'h0, q_full});
        wr(`SRG_OFF_CTRL, 32'h00000001);
        @(posedge clock);
        chk("q_full", 32'h0, {31'h0, q_full});
    endtask
    // With the clock enable low even a direct occurrence must not latch.
    task automatic t_freeze();
        @(posedge clock);
        ce <= 1'b0;
        direct_event <= 16'h0001;
        @(posedge clock);
        direct_event <= 16'h0000;
        @(posedge clock);
        ce <= 1'b1;
        rd(`SRG_OFF_EVENT, 32'h00000000);
    endtask
    // Refused accesses and the reset command.
    task automatic t_errors();
        logic [31:0] q;
        logic e;
        srg_host_i.xfer(1'b0, 12'h020, 32'h0, q, e);
        chk("pslverr", 32'h1, {31'h0, e});
        chk("prdata", 32'h0, q);
        srg_host_i.xfer(1'b1, `SRG_OFF_COND, 32'h0000FFFF, q, e);
        chk("pslverr", 32'h1, {31'h0, e});
        rd(`SRG_OFF_COND, 32'h00000001);
        wr(`SRG_OFF_CTRL, 32'h00000002);
        rd(`SRG_OFF_PTR, 32'h0000FFFF);
        rd(`SRG_OFF_NTR, 32'h00000000);
    endtask
    task automatic test_done();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // The whole sequence needs well under a thousand cycles.
    initial begin
        repeat (20000) @(posedge clock);
        fails++;
        test_done();
    end
    initial begin
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        t_reset();
        t_edges();
        t_summary();
        t_queue();
        t_freeze();
        t_errors();
        test_done();
    end
endmodule
